// *** rtl/qadc_frame_defs.svh ***
`ifndef QADC_FRAME_DEFS_SVH
`define QADC_FRAME_DEFS_SVH

// conversion framing counts, in serial clock falling edges
`define CONV_EDGES 5'd16
`define TRACK_LAST_EDGE 5'd3
`define HOLD_EDGE 5'd4
`define MSB_EDGE 5'd5
`define FIRST_EDGE 5'd1
`define IDLE_EDGE 5'd0

// control word capture
`define CTRL_LAST_RISE 5'd7
`define CTRL_SEL_HI 4
`define CTRL_SEL_LO 3

// result layout and reset values
`define RES_BITS 12
`define RES_MSB_TRIAL 12'h800
`define RES_ZERO 12'h000
`define DEFAULT_CHAN 2'h0
`define FIFO_WORDS 16

`endif

// *** rtl/qadc_frame_pkg.sv ***
package qadc_frame_pkg;

  // converter activity
  typedef enum logic [1:0] {
    st_pdown,
    st_track,
    st_convert
  } conv_state_t;

  // finished conversion: channel and straight binary code
  typedef struct packed {
    logic [1:0] chan;
    logic [11:0] code;
  } result_t;

  // pins from outside the clock domain
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
    logic cmp_ge;
  } pins_t;

endpackage

// *** rtl/quad_adc_frame_ctrl.sv ***
// Operation
// - track input for first three clocks
// - hold and convert clocks four to fifteen
// - result out msb first from fifth clock
// - output tristated while select high
// - power down while select high, between conversions
// - back-to-back conversions restart every sixteen edges
// - clock edges ignored while select high
// - select fall with clock low counts
// - select fall with clock high waits
// - control input taken on first eight rises
// - channel word applies to next conversion
// - works from power-up, channel one first
// - control bits four and three address channel
// - control bits 7,6,2,1,0 ignored
// - bit five ignored, bits four-three binary
// - twelve bit straight binary result
// - auto power down after sixteenth falling edge
// - result bits change after falling edges
`timescale 1ns/1ps
`include "qadc_frame_defs.svh"
`default_nettype none

// -----------------------------------------------------------------
// result fifo
// -----------------------------------------------------------------
module result_fifo
  #(
    parameter int WIDTH = 14,
    parameter int DEPTH = `FIFO_WORDS
  )
  (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
  );
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // full and empty from pointers with a wrap bit
  assign o_in_ready = !((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                        (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign o_out_valid = (wr_ptr_r != rd_ptr_r);
  assign push = i_ce && i_in_valid && o_in_ready;
  assign pop = i_ce && o_out_valid && i_out_ready;
  assign o_out_data = mem_r[rd_ptr_r[AW-1:0]];

  // storage
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  // pointers
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// -----------------------------------------------------------------
// serial frame and conversion sequencer
// -----------------------------------------------------------------
module quad_adc_frame_ctrl
  import qadc_frame_pkg::*;
  (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_cmp_ge,
    output logic o_dout,
    output logic o_dout_oe_n,
    output logic [1:0] o_chan_sel,
    output logic o_track,
    output logic o_hold,
    output logic o_power_down,
    output logic [11:0] o_dac_code,
    output result_t o_result,
    output logic o_result_valid,
    input wire logic i_result_ready,
    output logic o_overflow
  );

  logic [1:0] rst_sync_r;
  logic rst_n;
  pins_t pin_in;
  pins_t sync1_r;
  pins_t sync2_r;
  logic cs_q3_r;
  logic sclk_q3_r;
  logic cs_s;
  logic sclk_s;
  logic fall_evt;
  logic rise_evt;
  logic [4:0] fall_cnt_r;
  logic [4:0] fall_nxt;
  logic [4:0] rise_cnt_r;
  logic [6:0] shift_r;
  logic [7:0] ctrl_word;
  logic [1:0] next_chan_r;
  logic [1:0] cur_chan_r;
  conv_state_t state_r;
  logic [11:0] sar_r;
  logic [3:0] bit_idx;
  logic dout_r;
  logic res_push;
  logic fifo_in_ready;
  logic overflow_r;
  result_t res_word;

  // -----------------------------------------------------------------
  // reset release and pin synchronisers
  // -----------------------------------------------------------------
  // reset deasserts through two flops
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_sync_r <= 2'h0;
    end
    else if (i_ce)
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign pin_in = '{cs_n: i_cs_n, sclk: i_sclk, din: i_din,
                    cmp_ge: i_cmp_ge};

  // two flops per pin; the third stage feeds edge detection only
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, cmp_ge: 1'b0};
      sync2_r <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, cmp_ge: 1'b0};
      cs_q3_r <= 1'b1;
      sclk_q3_r <= 1'b0;
    end
    else if (i_ce)
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      cs_q3_r <= sync2_r.cs_n;
      sclk_q3_r <= sync2_r.sclk;
    end
  end
  assign cs_s = sync2_r.cs_n;
  assign sclk_s = sync2_r.sclk;

  // -----------------------------------------------------------------
  // internal clock edges
  // -----------------------------------------------------------------
  // gated clock edges
  assign fall_evt = i_ce && !cs_s &&
                    ((sclk_q3_r && !sclk_s) ||
                     (cs_q3_r && !sclk_s && !sclk_q3_r));
  assign rise_evt = i_ce && !cs_s && !sclk_q3_r && sclk_s;

  always_comb
  begin
    if ((fall_cnt_r == `IDLE_EDGE) || (fall_cnt_r == `CONV_EDGES))
    begin
      fall_nxt = `FIRST_EDGE;
    end
    else
    begin
      fall_nxt = fall_cnt_r + 5'd1;
    end
  end

  // falling edge position within the conversion
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fall_cnt_r <= `IDLE_EDGE;
    end
    else if (i_ce && cs_s)
    begin
      fall_cnt_r <= `IDLE_EDGE;
    end
    else if (fall_evt)
    begin
      fall_cnt_r <= fall_nxt;
    end
  end

  // -----------------------------------------------------------------
  // control word capture
  // -----------------------------------------------------------------
  assign ctrl_word = {shift_r, sync2_r.din};

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_cnt_r <= `IDLE_EDGE;
      shift_r <= 7'h00;
    end
    else if (i_ce && cs_s)
    begin
      rise_cnt_r <= `IDLE_EDGE;
    end
    else if (fall_evt && (fall_nxt == `FIRST_EDGE))
    begin
      rise_cnt_r <= `IDLE_EDGE;
    end
    else if (rise_evt && (rise_cnt_r <= `CTRL_LAST_RISE))
    begin
      rise_cnt_r <= rise_cnt_r + 5'd1;
      shift_r <= ctrl_word[6:0];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      next_chan_r <= `DEFAULT_CHAN;
    end
    else if (rise_evt && (rise_cnt_r == `CTRL_LAST_RISE))
    begin
      next_chan_r <= {ctrl_word[`CTRL_SEL_HI], ctrl_word[`CTRL_SEL_LO]};
    end
  end

  // -----------------------------------------------------------------
  // conversion sequencing
  // -----------------------------------------------------------------
  // power-up channel one
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_chan_r <= `DEFAULT_CHAN;
    end
    else if (fall_evt && (fall_nxt == `FIRST_EDGE))
    begin
      cur_chan_r <= next_chan_r;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= st_pdown;
    end
    else if (i_ce && cs_s)
    begin
      state_r <= st_pdown;
    end
    else if (fall_evt)
    begin
      case (fall_nxt)
        `FIRST_EDGE: state_r <= st_track;
        `HOLD_EDGE: state_r <= st_convert;
        `CONV_EDGES: state_r <= st_pdown;
        default: state_r <= state_r;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // successive approximation and serial output
  // -----------------------------------------------------------------
  assign bit_idx = 4'(`CONV_EDGES - fall_nxt);

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sar_r <= `RES_ZERO;
    end
    else if (fall_evt && (fall_nxt == `HOLD_EDGE))
    begin
      sar_r <= `RES_MSB_TRIAL;
    end
    else if (fall_evt && (fall_nxt >= `MSB_EDGE))
    begin
      sar_r[bit_idx] <= sync2_r.cmp_ge;
      if (bit_idx != 4'h0)
      begin
        sar_r[4'(bit_idx - 4'h1)] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_r <= 1'b0;
    end
    else if (i_ce && cs_s)
    begin
      dout_r <= 1'b0;
    end
    else if (fall_evt)
    begin
      dout_r <= (fall_nxt >= `MSB_EDGE) ? sync2_r.cmp_ge : 1'b0;
    end
  end

  assign o_dout_oe_n = cs_s;
  assign o_dout = dout_r;
  assign o_dac_code = sar_r;
  assign o_chan_sel = cur_chan_r;
  assign o_track = (state_r == st_track);
  assign o_hold = (state_r == st_convert);
  assign o_power_down = (state_r == st_pdown);

  // -----------------------------------------------------------------
  // finished results
  // -----------------------------------------------------------------
  // straight binary code
  assign res_push = fall_evt && (fall_nxt == `CONV_EDGES);
  assign res_word = '{chan: cur_chan_r,
                      code: {sar_r[11:1], sync2_r.cmp_ge}};

  // results lost on a full fifo are flagged until reset
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overflow_r <= 1'b0;
    end
    else if (res_push && !fifo_in_ready)
    begin
      overflow_r <= 1'b1;
    end
  end
  assign o_overflow = overflow_r;

  result_fifo #(.WIDTH($bits(result_t)), .DEPTH(`FIFO_WORDS)) u_fifo
  (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_in_valid(res_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(res_word),
    .o_out_valid(o_result_valid),
    .i_out_ready(i_result_ready),
    .o_out_data(o_result)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  sequence conv_start_s;
    fall_evt && (fall_nxt == `FIRST_EDGE);
  endsequence
  sequence third_fall_s;
    fall_evt && (fall_nxt == `TRACK_LAST_EDGE);
  endsequence
  sequence hold_fall_s;
    fall_evt && (fall_nxt == `HOLD_EDGE);
  endsequence

  track_start_a: assert property (
    conv_start_s |=> o_track && (fall_cnt_r == `FIRST_EDGE))
    else $error("track not entered on first falling edge");
  track_keep_a: assert property (
    third_fall_s |=> o_track && !o_hold)
    else $error("track left before fourth falling edge");
  hold_enter_a: assert property (
    hold_fall_s |=> o_hold && (fall_cnt_r == `HOLD_EDGE))
    else $error("hold not entered on fourth falling edge");
  msb_out_a: assert property (
    fall_evt && (fall_nxt == `MSB_EDGE)
    |=> o_dout == $past(sync2_r.cmp_ge))
    else $error("msb not driven on fifth falling edge");
  oe_idle_a: assert property (
    cs_s |-> o_dout_oe_n)
    else $error("output driven while deselected");
  sel_down_a: assert property (
    i_ce && cs_s |=> o_power_down && !o_dout)
    else $error("not powered down while deselected");
  gate_idle_a: assert property (
    (cs_s && i_ce) |=> (fall_cnt_r == `IDLE_EDGE) &&
    (rise_cnt_r == `IDLE_EDGE))
    else $error("edge counted while deselected");
  cs_low_edge_a: assert property (
    i_ce && !cs_s && cs_q3_r && !sclk_s && !sclk_q3_r
    |=> fall_cnt_r == `FIRST_EDGE)
    else $error("select fall with clock low not counted");
  cs_high_wait_a: assert property (
    i_ce && !cs_s && cs_q3_r && sclk_s |=> fall_cnt_r == `IDLE_EDGE)
    else $error("select fall with clock high counted");
  next_chan_a: assert property (
    conv_start_s |=> o_chan_sel == $past(next_chan_r))
    else $error("channel not taken from previous word");
  addr_field_a: assert property (
    rise_evt && (rise_cnt_r == `CTRL_LAST_RISE)
    |=> next_chan_r == $past({shift_r[3], shift_r[2]}))
    else $error("channel field decoded wrongly");
  auto_down_a: assert property (
    fall_evt && (fall_nxt == `CONV_EDGES) |=> o_power_down)
    else $error("no power down after sixteenth edge");
  lead_zero_a: assert property (
    fall_evt && (fall_nxt < `MSB_EDGE) |=> !o_dout)
    else $error("leading bit not zero");

endmodule

`default_nettype wire

// *** tb/qadc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// host serial port model
// -----------------------------------------------------------------
module qadc_host_model
  (
    input wire logic i_dout,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din
  );
  logic [7:0] ctl_q[16];
  logic [15:0] rx_q[16];

  // pins idle before the first frame
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end

  // one frame of n conversions, rest is the idle clock level
  task automatic frame(input int n, input logic rest);
    int j;
    o_sclk = rest;
    #200;
    o_cs_n = 1'b0;
    // select and clock falls kept apart
    if (rest)
    begin
      #100 o_sclk = 1'b0;
    end
    for (int k = 0; k < 16 * n; k++)
    begin
      j = k % 16;
      o_din = (j < 8) ? ctl_q[k/16][7-j] : ~ctl_q[k/16][15-j];
      #100 o_sclk = 1'b1;
      rx_q[k/16][15-j] = i_dout;
      #100;
      if (k < 16 * n - 1)
        o_sclk = 1'b0;
    end
    o_cs_n = 1'b1;
    o_din = ~o_din; // released line shows no stale value
    #300;
  endtask
endmodule

`default_nettype wire

// *** tb/test_quad_adc_serial_frame_control.sv ***
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// testbench top
// -----------------------------------------------------------------
module test_quad_adc_serial_frame_control;
  import qadc_frame_pkg::*;
  logic i_mclk;
  logic i_reset_n;
  logic i_ce;
  logic i_result_ready;
  logic cmp_ge;
  logic cs_n;
  logic sclk;
  logic din;
  logic o_dout;
  logic o_dout_oe_n;
  logic [1:0] o_chan_sel;
  logic o_track;
  logic o_hold;
  logic o_power_down;
  logic [11:0] o_dac_code;
  result_t o_result;
  logic o_result_valid;
  logic o_overflow;
  wire dout_pin;
  logic [11:0] ana[4];
  logic [2:0] st_log[$];
  result_t exp_q[$];
  logic [1:0] cur_chan;
  int mismatches;
  int total_checks;

  // analog inputs and comparator
  assign cmp_ge = (ana[o_chan_sel] >= o_dac_code);
  assign dout_pin = o_dout_oe_n ? 1'bz : o_dout;

  quad_adc_frame_ctrl quad_adc_frame_ctrl_i (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .i_cmp_ge(cmp_ge),
    .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n),
    .o_chan_sel(o_chan_sel), .o_track(o_track), .o_hold(o_hold),
    .o_power_down(o_power_down), .o_dac_code(o_dac_code),
    .o_result(o_result), .o_result_valid(o_result_valid),
    .i_result_ready(i_result_ready), .o_overflow(o_overflow));

  qadc_host_model qadc_host_model_i (
    .i_dout(dout_pin), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

  // clock
  initial
  begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  // converter phase seen at each host sampling edge
  always @(posedge sclk)
    if (cs_n === 1'b0)
      st_log.push_back({o_power_down, o_hold, o_track});

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // run a frame and judge results and phases of every conversion
  task automatic run(input int n, input logic rest);
    logic [1:0] ch;
    logic [15:0] ph;
    st_log.delete();
    qadc_host_model_i.frame(n, rest);
    for (int c = 0; c < n; c++)
    begin
      ch = (c == 0) ? cur_chan : qadc_host_model_i.ctl_q[c-1][4:3];
      check(qadc_host_model_i.rx_q[c], {4'h0, ana[ch]});
      exp_q.push_back({ch, ana[ch]});
      // expected phase per rising edge: track, hold, power down
      for (int j = 0; j < 16; j++)
      begin
        ph = (j < 3) ? 16'h1 : (j < 15) ? 16'h2 : 16'h4;
        check(16'(st_log[c*16+j]), ph);
      end
    end
    check(16'(st_log.size()), 16'(16 * n));
    cur_chan = qadc_host_model_i.ctl_q[n-1][4:3];
    check(16'(o_power_down), 16'h1);
    check(16'(o_dout_oe_n), 16'h1);
  endtask

  // first frame after power-up, clock resting low
  task automatic t_power_up;
    qadc_host_model_i.ctl_q[0] = 8'hf7;
    run(1, 1'b0);
    check(16'(o_chan_sel), 16'h0);
  endtask

  // four back-to-back conversions, clock resting high
  task automatic t_multi;
    qadc_host_model_i.ctl_q[0] = 8'h27;
    qadc_host_model_i.ctl_q[1] = 8'h18;
    qadc_host_model_i.ctl_q[2] = 8'h08;
    qadc_host_model_i.ctl_q[3] = 8'hd0;
    run(4, 1'b1);
    check(16'(o_overflow), 16'h0);
  endtask

  // reader stalls until the buffer refuses a result
  task automatic t_overflow;
    for (int c = 0; c < 12; c++)
      qadc_host_model_i.ctl_q[c] = 8'h08;
    run(12, 1'b0);
    check(16'(o_overflow), 16'h1);
    check(16'(o_result_valid), 16'h1);
  endtask

  // drain the buffer until empty, in arrival order
  task automatic t_drain;
    int n;
    n = 0;
    @(posedge i_mclk);
    #1 i_result_ready = 1'b1;
    // enable low must freeze the buffer: no pop while ready is high
    i_ce = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 i_ce = 1'b1;
    for (int i = 0; i < 40 && o_result_valid !== 1'b0; i++)
    begin
      check({2'h0, o_result}, {2'h0, exp_q.pop_front()});
      n++;
      @(posedge i_mclk);
      #1;
    end
    i_result_ready = 1'b0;
    check(16'(n), 16'h10);
    check(16'(o_overflow), 16'h1);
  endtask

  // watchdog
  initial
  begin
    #200000;
    mismatches++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    ana = '{12'h5a3, 12'hfff, 12'h000, 12'h801};
    i_reset_n = 1'b0;
    i_ce = 1'b1;
    i_result_ready = 1'b0;
    cur_chan = 2'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (5) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    repeat (6) @(posedge i_mclk);
    #1;
    t_power_up();
    t_multi();
    t_overflow();
    t_drain();
    wrap_up();
  end
endmodule

`default_nettype wire
